/* rtl/fsps_pkg.sv */
// Function
// - Sixty-four byte holding registers, filled one byte per table write.
// - Program or erase only while write permit is set.
// - Valid start begins self-timed write; core stalls until timer ends.
// - Word select programs only two bytes per write cycle.
// - Error flag set when a reset interrupts a running write.
// - Control bits: word 5, erase 4, error 3, permit 2, start 1.
// - Unlock register holds no storage, only feeds the key sequence.
// - Pointer split low, high, upper; upper holds bits 21 and 20..16.
// - Holding registers keep contents after a write completes.
// - Hardware clears start bit at cycle end; software only sets it.
// - Pointer bits 21..10 select the 1024-byte target block.
package fsps_pkg;
  // ----------------------------------------
  // Register selects
  // ----------------------------------------
  localparam logic [2:0] FSPS_SEL_PTR_LOW = 3'h0;
  localparam logic [2:0] FSPS_SEL_PTR_HIGH = 3'h1;
  localparam logic [2:0] FSPS_SEL_PTR_UPPER = 3'h2;
  localparam logic [2:0] FSPS_SEL_LATCH = 3'h3;
  localparam logic [2:0] FSPS_SEL_UNLOCK = 3'h4;
  localparam logic [2:0] FSPS_SEL_CONTROL = 3'h5;
  // ----------------------------------------
  // Control fields and keys
  // ----------------------------------------
  localparam int FSPS_BIT_WORD = 5;
  localparam int FSPS_BIT_ERASE = 4;
  localparam int FSPS_BIT_ERR = 3;
  localparam int FSPS_BIT_PERMIT = 2;
  localparam int FSPS_BIT_START = 1;
  localparam logic [7:0] FSPS_KEY1 = 8'h55;
  localparam logic [7:0] FSPS_KEY2 = 8'hAA;
  localparam logic [7:0] FSPS_RESET_BYTE = 8'h00;
  localparam int FSPS_HOLD_COUNT = 64;
  localparam int FSPS_PTR_W = 22;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int FSPS_CLK_MHZ = 10;
  localparam int FSPS_WRITE_US = 3000;
  localparam int FSPS_WRITE_CYC = FSPS_WRITE_US * FSPS_CLK_MHZ;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FSPS_IDLE = 2'b00,
    FSPS_KEY1_OK = 2'b01,
    FSPS_KEY2_OK = 2'b11
  } fsps_unlock_t;
  typedef enum logic [1:0] {
    FSPS_OP_PROG_BLOCK = 2'b00,
    FSPS_OP_PROG_WORD = 2'b01,
    FSPS_OP_ERASE = 2'b10
  } fsps_op_t;
  typedef struct packed {
    logic [11:0] block;
    logic [5:0] offset;
    fsps_op_t op;
  } fsps_cmd_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } fsps_reg_t;
endpackage

/* rtl/fsps_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module fsps_sequencer #(
  parameter int WRITE_CYCLES = fsps_pkg::FSPS_WRITE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Reset cause: a master clear or watchdog reset is pending
  input wire logic abort_reset,
  // Register port
  input wire fsps_pkg::fsps_reg_t reg_req,
  output logic [7:0] reg_rdata,
  // Table write strobe: pointer step mode
  input wire logic table_write_op,
  input wire logic [1:0] table_step,
  input wire logic table_read_op,
  input wire logic [7:0] table_read_data,
  // Core stall and memory array command
  output logic core_stall,
  output logic mem_go,
  output fsps_pkg::fsps_cmd_t mem_cmd,
  output logic [7:0] hold_byte,
  input wire logic [5:0] hold_index
);
  import fsps_pkg::*;
  // Timer needs at least two cycles to count down and clear start
  if (WRITE_CYCLES < 2) begin : g_cycles_check
    $error("WRITE_CYCLES too small");
  end

  logic [FSPS_PTR_W-1:0] ptr_reg;
  logic [7:0] latch_reg;
  logic [7:0] hold_reg [FSPS_HOLD_COUNT];
  logic word_reg, erase_reg, err_reg, permit_reg, start_reg;
  fsps_unlock_t key_reg;
  logic [31:0] timer_reg;
  logic [7:0] ctrl_view;
  logic wr_ctrl, wr_key, fire;

  assign wr_ctrl = reg_req.wr && reg_req.sel == FSPS_SEL_CONTROL;
  assign wr_key = reg_req.wr && reg_req.sel == FSPS_SEL_UNLOCK;
  // Start honoured only after a fresh key pair and with permit
  assign fire = wr_ctrl && reg_req.wdata[FSPS_BIT_START] && !start_reg
      && key_reg == FSPS_KEY2_OK && permit_reg;

  // ----------------------------------------
  // Unlock key tracker
  // ----------------------------------------
  // Any other register write breaks the sequence
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      key_reg <= FSPS_IDLE;
    end else if (wr_key) begin
      if (reg_req.wdata == FSPS_KEY1) key_reg <= FSPS_KEY1_OK;
      else if (reg_req.wdata == FSPS_KEY2 && key_reg == FSPS_KEY1_OK) key_reg <= FSPS_KEY2_OK;
      else key_reg <= FSPS_IDLE;
    end else if (reg_req.wr && !(wr_ctrl && key_reg == FSPS_KEY2_OK)) begin
      key_reg <= FSPS_IDLE;
    end else if (wr_ctrl) begin
      key_reg <= FSPS_IDLE;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      word_reg <= 1'b0;
      erase_reg <= 1'b0;
      permit_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      if (wr_ctrl && !start_reg) begin
        word_reg <= reg_req.wdata[FSPS_BIT_WORD];
        erase_reg <= reg_req.wdata[FSPS_BIT_ERASE];
        permit_reg <= reg_req.wdata[FSPS_BIT_PERMIT];
      end
      if (fire) start_reg <= 1'b1;
      else if (start_reg && timer_reg == 32'h0) start_reg <= 1'b0;
    end
  end

  // Error flag: caught when an abort reset hits a running cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_reg <= 1'b0;
    end else if (abort_reset && start_reg) begin
      err_reg <= 1'b1;
    end else if (wr_ctrl && !reg_req.wdata[FSPS_BIT_ERR]) begin
      err_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Self-timer
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_reg <= 32'h0;
    end else if (fire) begin
      timer_reg <= 32'(WRITE_CYCLES - 1);
    end else if (start_reg && timer_reg != 32'h0) begin
      timer_reg <= timer_reg - 32'h1;
    end
  end

  // ----------------------------------------
  // Table pointer and latch
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= '0;
    end else if (reg_req.wr && reg_req.sel == FSPS_SEL_PTR_LOW) begin
      ptr_reg[7:0] <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.sel == FSPS_SEL_PTR_HIGH) begin
      ptr_reg[15:8] <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.sel == FSPS_SEL_PTR_UPPER) begin
      ptr_reg[21:16] <= reg_req.wdata[5:0];
    end else if ((table_write_op || table_read_op) && table_step != 2'h0) begin
      // Steps touch low 21 bits only; 2 = decrement, 1/3 = increment
      if (table_step == 2'h2) ptr_reg[20:0] <= ptr_reg[20:0] - 21'h1;
      else ptr_reg[20:0] <= ptr_reg[20:0] + 21'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latch_reg <= FSPS_RESET_BYTE;
    end else if (reg_req.wr && reg_req.sel == FSPS_SEL_LATCH) begin
      latch_reg <= reg_req.wdata;
    end else if (table_read_op) begin
      latch_reg <= table_read_data;
    end
  end

  // Pre-increment mode writes at the stepped address
  logic [5:0] hold_wr_idx;
  assign hold_wr_idx = (table_step == 2'h3) ? 6'(ptr_reg[5:0] + 6'h1) : ptr_reg[5:0];

  // ----------------------------------------
  // Holding registers, never cleared by a write cycle
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (table_write_op && !start_reg) begin
      hold_reg[hold_wr_idx] <= latch_reg;
    end
  end

  // ----------------------------------------
  // Array command and read path
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_go <= 1'b0;
      mem_cmd <= '0;
      hold_byte <= FSPS_RESET_BYTE;
    end else begin
      mem_go <= fire;
      hold_byte <= hold_reg[hold_index];
      if (fire) begin
        mem_cmd.block <= ptr_reg[21:10];
        mem_cmd.offset <= ptr_reg[5:0];
        if (erase_reg) mem_cmd.op <= FSPS_OP_ERASE;
        else if (word_reg) mem_cmd.op <= FSPS_OP_PROG_WORD;
        else mem_cmd.op <= FSPS_OP_PROG_BLOCK;
      end
    end
  end

  assign core_stall = start_reg;
  assign ctrl_view = {2'b00, word_reg, erase_reg, err_reg, permit_reg, start_reg, 1'b0};

  // Read mux
  always_comb begin
    if (reg_req.sel == FSPS_SEL_PTR_LOW) reg_rdata = ptr_reg[7:0];
    else if (reg_req.sel == FSPS_SEL_PTR_HIGH) reg_rdata = ptr_reg[15:8];
    else if (reg_req.sel == FSPS_SEL_PTR_UPPER) reg_rdata = {2'b00, ptr_reg[21:16]};
    else if (reg_req.sel == FSPS_SEL_LATCH) reg_rdata = latch_reg;
    else if (reg_req.sel == FSPS_SEL_CONTROL) reg_rdata = ctrl_view;
    else reg_rdata = 8'h00;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  start_needs_key_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(start_reg) |-> $past(key_reg == FSPS_KEY2_OK && permit_reg))
    else $error("start without unlock or permit");
  stall_follows_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    fire |=> core_stall && timer_reg == 32'(WRITE_CYCLES - 1))
    else $error("stall or timer not loaded");
  stall_holds_a: assert property (@(posedge sys_clk) disable iff (rst)
    core_stall && timer_reg != 32'h0 |=> core_stall)
    else $error("stall dropped early");
  go_on_fire_a: assert property (@(posedge sys_clk) disable iff (rst)
    fire |=> mem_go && start_reg)
    else $error("fire lost");
  start_ends_a: assert property (@(posedge sys_clk) disable iff (rst)
    start_reg && timer_reg == 32'h0 && !fire |=> !start_reg)
    else $error("start not cleared");
  err_on_abort_a: assert property (@(posedge sys_clk) disable iff (rst)
    abort_reset && start_reg |=> err_reg)
    else $error("error flag missing");
  block_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    fire |=> mem_cmd.block == $past(ptr_reg[21:10]))
    else $error("block select wrong");
  word_op_a: assert property (@(posedge sys_clk) disable iff (rst)
    fire && word_reg && !erase_reg |=> mem_cmd.op == FSPS_OP_PROG_WORD)
    else $error("word mode lost");
  ctrl_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_req.sel == FSPS_SEL_CONTROL |-> reg_rdata[7:6] == 2'b00 && !reg_rdata[0])
    else $error("reserved bits set");
  unlock_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_req.sel == FSPS_SEL_UNLOCK |-> reg_rdata == 8'h00)
    else $error("unlock readable");
  block_cv: cover property (@(posedge sys_clk) disable iff (rst)
    fire && !word_reg && !erase_reg);
  word_cv: cover property (@(posedge sys_clk) disable iff (rst) fire && word_reg);
  erase_cv: cover property (@(posedge sys_clk) disable iff (rst) fire && erase_reg);
  abort_cv: cover property (@(posedge sys_clk) disable iff (rst) abort_reset && start_reg);
endmodule
`default_nettype wire

/* testbench/test_flash_self_program_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_flash_self_program_sequencer;
  import fsps_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic abort_reset = 1'b0;
  logic table_write_op = 1'b0;
  logic table_read_op = 1'b0;
  logic [1:0] table_step = 2'h0;
  logic [7:0] table_read_data = 8'h00;
  logic [5:0] hold_index = 6'h00;
  fsps_reg_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic [7:0] hold_byte;
  logic core_stall;
  logic mem_go;
  fsps_cmd_t mem_cmd;
  fsps_cmd_t exp_q[$];
  logic [7:0] img[64];
  logic [21:0] base;
  int error_cnt = 0;
  int comparisons = 0;

  // ----------------------------------------
  // Clock and design
  // ----------------------------------------
  always #50 sys_clk = ~sys_clk;

  fsps_sequencer #(.WRITE_CYCLES(8)) DUT (
    .sys_clk(sys_clk), .rst(rst), .abort_reset(abort_reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .table_write_op(table_write_op), .table_step(table_step),
    .table_read_op(table_read_op), .table_read_data(table_read_data),
    .core_stall(core_stall), .mem_go(mem_go), .mem_cmd(mem_cmd),
    .hold_byte(hold_byte), .hold_index(hold_index)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One register write pulse, released a cycle later
  task automatic wreg(input logic [2:0] s, input logic [7:0] d);
    @(negedge sys_clk) reg_req = '{1'b1, 1'b0, s, d};
    @(negedge sys_clk) reg_req.wr = 1'b0;
  endtask

  // Masked register read, data settles combinationally
  task automatic rreg(input logic [2:0] s, input logic [7:0] m, input logic [7:0] e);
    @(negedge sys_clk) reg_req = '{1'b0, 1'b1, s, 8'h00};
    #1 chk("register read", reg_rdata & m, e);
  endtask

  // Latch a byte, then one table write with the given pointer step
  task automatic twrite(input logic [7:0] d, input logic [1:0] step);
    wreg(FSPS_SEL_LATCH, d);
    @(negedge sys_clk) table_write_op = 1'b1;
    table_step = step;
    @(negedge sys_clk) table_write_op = 1'b0;
  endtask

  task automatic setptr(input logic [21:0] p);
    wreg(FSPS_SEL_PTR_LOW, p[7:0]);
    wreg(FSPS_SEL_PTR_HIGH, p[15:8]);
    wreg(FSPS_SEL_PTR_UPPER, {2'h0, p[21:16]});
  endtask

  // Key sequence and start; counts stall cycles, may break keys or abort
  task automatic go(input logic [7:0] ctl, input fsps_cmd_t c, input bit good,
                    input bit ab, input bit brk);
    int n;
    // Permit and mode bits first, start kept clear
    wreg(FSPS_SEL_CONTROL, ctl & 8'hFD);
    wreg(FSPS_SEL_UNLOCK, FSPS_KEY1);
    if (brk) wreg(FSPS_SEL_LATCH, 8'h00);
    wreg(FSPS_SEL_UNLOCK, FSPS_KEY2);
    if (good) exp_q.push_back(c);
    wreg(FSPS_SEL_CONTROL, ctl);
    n = (core_stall === 1'b1) ? 1 : 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge sys_clk) abort_reset = ab && (i == 3);
      if (core_stall === 1'b1) n++;
    end
    if (!ab) chk("stall cycles", n, good ? 8 : 0);
  endtask

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(negedge sys_clk) begin
    if (!rst && mem_go === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected start", 1, 0);
      else chk("memory command", mem_cmd, exp_q.pop_front());
    end
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #(100 * 20000);
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(19961));
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    rreg(FSPS_SEL_CONTROL, 8'hFF, 8'h00);
    // Erase one row, then rewrite it as sixteen filled blocks
    base = (22'($urandom) & 22'h3FFC00) | 22'h000400;
    setptr(base);
    go(8'h16, {base[21:10], 6'h00, FSPS_OP_ERASE}, 1, 0, 0);
    for (int k = 0; k < 16; k++) begin
      setptr(base + 22'(k * 64) - 22'h1);
      for (int i = 0; i < 64; i++) begin
        img[i] = 8'($urandom);
        twrite(img[i], 2'h3);
      end
      go(8'h06, {base[21:10], 6'h3F, FSPS_OP_PROG_BLOCK}, 1, 0, 0);
      rreg(FSPS_SEL_CONTROL, 8'hFF, 8'h04);
      for (int i = 0; i < 64; i++) begin
        @(negedge sys_clk) hold_index = 6'(i);
        @(negedge sys_clk) chk("holding byte", hold_byte, img[i]);
      end
    end
    // Word write, then erase on the same pointer
    base = 22'($urandom) & 22'h3FFFFE;
    setptr(base);
    rreg(FSPS_SEL_PTR_UPPER, 8'hFF, {2'h0, base[21:16]});
    rreg(FSPS_SEL_PTR_HIGH, 8'hFF, base[15:8]);
    twrite(8'hA5, 2'h1);
    twrite(8'h5A, 2'h0);
    go(8'h26, {base[21:10], base[5:0] + 6'h1, FSPS_OP_PROG_WORD}, 1, 0, 0);
    go(8'h16, {base[21:10], base[5:0] + 6'h1, FSPS_OP_ERASE}, 1, 0, 0);
    // Refused starts
    go(8'h02, '0, 0, 0, 0);
    go(8'h06, '0, 0, 0, 1);
    // Reset cause hitting a running write
    go(8'h06, {base[21:10], base[5:0] + 6'h1, FSPS_OP_PROG_BLOCK}, 1, 1, 0);
    rreg(FSPS_SEL_CONTROL, 8'h08, 8'h08);
    go(8'h06, {base[21:10], base[5:0] + 6'h1, FSPS_OP_PROG_BLOCK}, 1, 0, 0);
    wreg(FSPS_SEL_CONTROL, 8'h00);
    rreg(FSPS_SEL_CONTROL, 8'hFF, 8'h00);
    // Read back through the latch, pointer post-increments
    @(negedge sys_clk) table_read_op = 1'b1;
    table_step = 2'h1;
    table_read_data = 8'($urandom);
    @(negedge sys_clk) table_read_op = 1'b0;
    rreg(FSPS_SEL_LATCH, 8'hFF, table_read_data);
    rreg(FSPS_SEL_PTR_LOW, 8'hFF, 8'(base[7:0] + 8'h2));
    repeat (5) @(negedge sys_clk);
    chk("pending starts", exp_q.size(), 0);
    end_of_test();
  end
endmodule
`default_nettype wire
